//--- logic/dgp_params.svh
// Purpose: Constants of the dual GPIO port block: register indexes, field positions, reset values.
// Assumes: Register byte address is four times the index.
// Notes:   Definitions only.
`ifndef DGP_PARAMS_SVH
`define DGP_PARAMS_SVH

// Register indexes
`define DGP_IDX_NAR_LATCH  12'h009
`define DGP_IDX_WIDE_LATCH 12'h00b
`define DGP_IDX_NAR_PIN    12'h016
`define DGP_IDX_WIDE_PIN   12'h018
`define DGP_IDX_NAR_DIR    12'hf23
`define DGP_IDX_WIDE_DIR   12'hf25
`define DGP_IDX_NAR_PU     12'hf30
`define DGP_IDX_NAR_FUNC   12'hf3d
`define DGP_IDX_WIDE_FUNC  12'hf3f
`define DGP_IDX_NAR_DRIVE  12'hf4a
`define DGP_IDX_WIDE_DRIVE 12'hf4c
`define DGP_IDX_ROUTE      12'hf60

// Field positions
`define DGP_NAR_LSB        0
`define DGP_WIDE_LSB       4
`define DGP_WFUNC_LSB      4
`define DGP_ROUTE_NAR_SWAP 0
`define DGP_ROUTE_WIDE_SWAP 1
`define DGP_ROUTE_SIO_SEL  2

// Reset values
`define DGP_RST_NAR        2'h0
`define DGP_RST_WIDE       4'h0
`define DGP_RST_WFUNC      3'h0
`define DGP_RST_ROUTE      3'h0

`endif

//--- logic/dgp_pkg.sv
// Purpose: Types shared by the dual GPIO port block.
// Assumes: dgp_params.svh holds the numbers.
// Notes:   Register decode lives here since both bus paths use it.
`include "dgp_params.svh"

package dgp_pkg;

	// Register selector after address decode
	typedef enum logic [3:0] {
		DGP_REG_NONE       = 4'h0,
		DGP_REG_NAR_LATCH  = 4'h1,
		DGP_REG_WIDE_LATCH = 4'h2,
		DGP_REG_NAR_PIN    = 4'h3,
		DGP_REG_WIDE_PIN   = 4'h4,
		DGP_REG_NAR_DIR    = 4'h5,
		DGP_REG_WIDE_DIR   = 4'h6,
		DGP_REG_NAR_PU     = 4'h7,
		DGP_REG_NAR_FUNC   = 4'h8,
		DGP_REG_WIDE_FUNC  = 4'h9,
		DGP_REG_NAR_DRIVE  = 4'ha,
		DGP_REG_WIDE_DRIVE = 4'hb,
		DGP_REG_ROUTE      = 4'hc
	} dgp_reg_t;

	typedef enum logic [1:0] {
		DGP_RESP_OKAY   = 2'h0,
		DGP_RESP_SLVERR = 2'h2
	} dgp_resp_t;

	// Per-pin settings handed to a pin cell
	typedef struct packed {
		logic dir;
		logic latch;
		logic func_en;
		logic func_out;
		logic open_drain;
		logic pullup_en;
	} dgp_pin_cfg_t;

	// Per-pin results of a pin cell
	typedef struct packed {
		logic out;
		logic oe;
		logic pullup_on;
		logic rd;
	} dgp_pin_drv_t;

	// Word index to register selector
	function automatic dgp_reg_t dgp_decode(input logic [11:0] idx);
		unique case (idx)
			`DGP_IDX_NAR_LATCH:  return DGP_REG_NAR_LATCH;
			`DGP_IDX_WIDE_LATCH: return DGP_REG_WIDE_LATCH;
			`DGP_IDX_NAR_PIN:    return DGP_REG_NAR_PIN;
			`DGP_IDX_WIDE_PIN:   return DGP_REG_WIDE_PIN;
			`DGP_IDX_NAR_DIR:    return DGP_REG_NAR_DIR;
			`DGP_IDX_WIDE_DIR:   return DGP_REG_WIDE_DIR;
			`DGP_IDX_NAR_PU:     return DGP_REG_NAR_PU;
			`DGP_IDX_NAR_FUNC:   return DGP_REG_NAR_FUNC;
			`DGP_IDX_WIDE_FUNC:  return DGP_REG_WIDE_FUNC;
			`DGP_IDX_NAR_DRIVE:  return DGP_REG_NAR_DRIVE;
			`DGP_IDX_WIDE_DRIVE: return DGP_REG_WIDE_DRIVE;
			`DGP_IDX_ROUTE:      return DGP_REG_ROUTE;
			default:             return DGP_REG_NONE;
		endcase
	endfunction

endpackage

//--- logic/dgp_pin_cell.sv
// Purpose: Output driver, pull-up gate and read-back of one port pin.
// Assumes: Pin level arrives synchronous to the system clock.
// Notes:   Open drain never drives high; the wire pull-up or board supplies the high level.
module dgp_pin_cell
	import dgp_pkg::*;
#(
	parameter bit HAS_PULLUP = 1'b1
)
(
	input  dgp_pin_cfg_t cfg,
	input  wire logic    pin_in,
	output dgp_pin_drv_t drv
);

	logic value;

	// Function output replaces the latch when selected
	assign value = cfg.func_en ? cfg.func_out : cfg.latch;

	////////////////////////////////////////////////////////////////////////////////
	// Drive, pull-up and read-back
	always_comb
	begin
		drv.oe        = cfg.dir && !(cfg.open_drain && value);
		drv.out       = cfg.dir && !cfg.open_drain && value;
		drv.pullup_on = HAS_PULLUP && cfg.pullup_en && (!cfg.dir || cfg.open_drain);
		drv.rd        = (!cfg.dir || cfg.open_drain) ? pin_in : 1'b0;
	end

endmodule // dgp_pin_cell

//--- logic/dgp_top.sv
// Purpose: Two-bit UART port and four-bit upper-nibble serial port with AXI4-Lite registers.
// Assumes: Pins and peripheral signals are synchronous to clock; one bus access of each kind at a time.
// Notes:   Receive outputs idle high while the routed pin is an output.
`include "dgp_params.svh"

module dgp_top
	import dgp_pkg::*;
#(
	parameter int ADDR_W = 16,
	parameter int NAR_W  = 2,
	parameter int WIDE_W = 4
)
(
	input  wire logic              clock,
	input  wire logic              rst,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic [NAR_W-1:0]  narrow_pin_in,
	output logic [NAR_W-1:0]       narrow_pin_out,
	output logic [NAR_W-1:0]       narrow_pin_oe,
	output logic [NAR_W-1:0]       narrow_pullup_on,
	input  wire logic [WIDE_W-1:0] wide_pin_in,
	output logic [WIDE_W-1:0]      wide_pin_out,
	output logic [WIDE_W-1:0]      wide_pin_oe,
	input  wire logic              second_uart_transmit,
	output logic                   second_uart_receive,
	input  wire logic              first_uart_transmit,
	output logic                   first_uart_receive,
	input  wire logic              sync_serial_clock,
	input  wire logic              sync_serial_data_out,
	output logic                   sync_serial_data_in
);

	// Control registers
	logic [NAR_W-1:0]  nar_latch_q;
	logic [NAR_W-1:0]  nar_dir_q;
	logic [NAR_W-1:0]  nar_func_q;
	logic [NAR_W-1:0]  nar_drive_q;
	logic [NAR_W-1:0]  nar_pu_q;
	logic [WIDE_W-1:0] wide_latch_q;
	logic [WIDE_W-1:0] wide_dir_q;
	logic [2:0]        wide_func_q;
	logic [WIDE_W-1:0] wide_drive_q;
	logic [2:0]        route_q;

	// Bus slave state
	logic              aw_full_q;
	logic [11:0]       aw_idx_q;
	logic              w_full_q;
	logic [31:0]       wdata_q;
	logic              wstrb0_q;
	logic              bvalid_q;
	logic [1:0]        bresp_q;
	logic              rvalid_q;
	logic [31:0]       rdata_q;
	logic [1:0]        rresp_q;
	logic              wr_fire;
	logic              wr_en;
	dgp_reg_t          wr_sel;
	dgp_reg_t          rd_sel;
	logic [7:0]        rd_byte;

	// Pin cell wiring
	dgp_pin_cfg_t      nar_cfg  [NAR_W];
	dgp_pin_drv_t      nar_drv  [NAR_W];
	dgp_pin_cfg_t      wide_cfg [WIDE_W];
	dgp_pin_drv_t      wide_drv [WIDE_W];
	logic [NAR_W-1:0]  nar_rd;
	logic [WIDE_W-1:0] wide_rd;
	logic [WIDE_W-1:0] wide_fen;
	logic [WIDE_W-1:0] wide_fout;
	logic              nar_swap;
	logic              wide_swap;
	logic              sio_sel;

	assign nar_swap  = route_q[`DGP_ROUTE_NAR_SWAP];
	assign wide_swap = route_q[`DGP_ROUTE_WIDE_SWAP];
	assign sio_sel   = route_q[`DGP_ROUTE_SIO_SEL];

	////////////////////////////////////////////////////////////////////////////////
	// Write channel: address and data taken in either order, committed together
	assign s_axi_awready = !aw_full_q && !bvalid_q;
	assign s_axi_wready  = !w_full_q && !bvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign wr_fire       = aw_full_q && w_full_q;
	assign wr_sel        = dgp_decode(aw_idx_q);
	assign wr_en         = wr_fire && wstrb0_q;         // Registers live in byte lane 0 only

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			aw_full_q <= 1'b0;
			aw_idx_q  <= 12'h000;
			w_full_q  <= 1'b0;
			wdata_q   <= 32'h0000_0000;
			wstrb0_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= DGP_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_full_q <= 1'b1;
				aw_idx_q  <= s_axi_awaddr[13:2];
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_full_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb0_q <= s_axi_wstrb[0];
			end
			if (wr_fire)
			begin
				aw_full_q <= 1'b0;
				w_full_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= (wr_sel == DGP_REG_NONE) ? DGP_RESP_SLVERR : DGP_RESP_OKAY;
			end
			else if (bvalid_q && s_axi_bready)
			begin
				bvalid_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Narrow port registers; only the implemented bits are stored
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			nar_latch_q <= `DGP_RST_NAR;
			nar_dir_q   <= `DGP_RST_NAR;
			nar_func_q  <= `DGP_RST_NAR;
			nar_drive_q <= `DGP_RST_NAR;
			nar_pu_q    <= `DGP_RST_NAR;
		end
		else if (wr_en)
		begin
			unique case (wr_sel)
				DGP_REG_NAR_LATCH: nar_latch_q <= wdata_q[`DGP_NAR_LSB +: NAR_W];
				DGP_REG_NAR_DIR:   nar_dir_q   <= wdata_q[`DGP_NAR_LSB +: NAR_W];
				DGP_REG_NAR_FUNC:  nar_func_q  <= wdata_q[`DGP_NAR_LSB +: NAR_W];
				DGP_REG_NAR_DRIVE: nar_drive_q <= wdata_q[`DGP_NAR_LSB +: NAR_W];
				DGP_REG_NAR_PU:    nar_pu_q    <= wdata_q[`DGP_NAR_LSB +: NAR_W];
				default:           nar_latch_q <= nar_latch_q;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Wide port and routing registers; low nibble is stored only by the routing register
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			wide_latch_q <= `DGP_RST_WIDE;
			wide_dir_q   <= `DGP_RST_WIDE;
			wide_func_q  <= `DGP_RST_WFUNC;
			wide_drive_q <= `DGP_RST_WIDE;
			route_q      <= `DGP_RST_ROUTE;
		end
		else if (wr_en)
		begin
			unique case (wr_sel)
				DGP_REG_WIDE_LATCH: wide_latch_q <= wdata_q[`DGP_WIDE_LSB +: WIDE_W];
				DGP_REG_WIDE_DIR:   wide_dir_q   <= wdata_q[`DGP_WIDE_LSB +: WIDE_W];
				DGP_REG_WIDE_FUNC:  wide_func_q  <= wdata_q[`DGP_WFUNC_LSB +: 3];
				DGP_REG_WIDE_DRIVE: wide_drive_q <= wdata_q[`DGP_WIDE_LSB +: WIDE_W];
				DGP_REG_ROUTE:      route_q      <= wdata_q[2:0];
				default:            route_q      <= route_q;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read channel: one read in flight, data captured at the address edge
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign rd_sel        = dgp_decode(s_axi_araddr[13:2]);

	// Read mux; unused positions fill with zero
	always_comb
	begin
		rd_byte = 8'h00;
		unique case (rd_sel)
			DGP_REG_NAR_LATCH:  rd_byte[`DGP_NAR_LSB +: NAR_W]    = nar_latch_q;
			DGP_REG_NAR_PIN:    rd_byte[`DGP_NAR_LSB +: NAR_W]    = nar_rd;
			DGP_REG_NAR_DIR:    rd_byte[`DGP_NAR_LSB +: NAR_W]    = nar_dir_q;
			DGP_REG_NAR_PU:     rd_byte[`DGP_NAR_LSB +: NAR_W]    = nar_pu_q;
			DGP_REG_NAR_FUNC:   rd_byte[`DGP_NAR_LSB +: NAR_W]    = nar_func_q;
			DGP_REG_NAR_DRIVE:  rd_byte[`DGP_NAR_LSB +: NAR_W]    = nar_drive_q;
			DGP_REG_WIDE_LATCH: rd_byte[`DGP_WIDE_LSB +: WIDE_W]  = wide_latch_q;
			DGP_REG_WIDE_PIN:   rd_byte[`DGP_WIDE_LSB +: WIDE_W]  = wide_rd;
			DGP_REG_WIDE_DIR:   rd_byte[`DGP_WIDE_LSB +: WIDE_W]  = wide_dir_q;
			DGP_REG_WIDE_FUNC:  rd_byte[`DGP_WFUNC_LSB +: 3]      = wide_func_q;
			DGP_REG_WIDE_DRIVE: rd_byte[`DGP_WIDE_LSB +: WIDE_W]  = wide_drive_q;
			DGP_REG_ROUTE:      rd_byte[2:0]                      = route_q;
			default:            rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= DGP_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_q <= 1'b1;
			rdata_q  <= {24'h00_0000, rd_byte};
			rresp_q  <= (rd_sel == DGP_REG_NONE) ? DGP_RESP_SLVERR : DGP_RESP_OKAY;
		end
		else if (rvalid_q && s_axi_rready)
		begin
			rvalid_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Narrow port pins: both carry the second UART transmit when function is set
	generate
		for (genvar i = 0; i < NAR_W; i++)
		begin : g_nar
			assign nar_cfg[i] = '{dir: nar_dir_q[i], latch: nar_latch_q[i], func_en: nar_func_q[i],
			                      func_out: second_uart_transmit, open_drain: nar_drive_q[i],
			                      pullup_en: nar_pu_q[i]};
			dgp_pin_cell #(.HAS_PULLUP(1'b1)) u_cell (
				.cfg    (nar_cfg[i]),
				.pin_in (narrow_pin_in[i]),
				.drv    (nar_drv[i])
			);
			assign narrow_pin_out[i]   = nar_drv[i].out;
			assign narrow_pin_oe[i]    = nar_drv[i].oe;
			assign narrow_pullup_on[i] = nar_drv[i].pullup_on;
			assign nar_rd[i]           = nar_drv[i].rd;
		end
	endgenerate

	// Receive comes from the upper pin unless swapped; idle high when that pin drives
	assign second_uart_receive = nar_swap ? (nar_dir_q[0] ? 1'b1 : narrow_pin_in[0])
	                                      : (nar_dir_q[1] ? 1'b1 : narrow_pin_in[1]);

	////////////////////////////////////////////////////////////////////////////////
	// Wide port pins: index 0..3 stand for bits 4..7; top pin has no function
	assign wide_fen  = {1'b0, wide_func_q};
	assign wide_fout = {1'b0, sync_serial_clock, first_uart_transmit,
	                    sio_sel ? sync_serial_data_out : first_uart_transmit};

	generate
		for (genvar j = 0; j < WIDE_W; j++)
		begin : g_wide
			assign wide_cfg[j] = '{dir: wide_dir_q[j], latch: wide_latch_q[j], func_en: wide_fen[j],
			                       func_out: wide_fout[j], open_drain: wide_drive_q[j], pullup_en: 1'b0};
			dgp_pin_cell #(.HAS_PULLUP(1'b0)) u_cell (
				.cfg    (wide_cfg[j]),
				.pin_in (wide_pin_in[j]),
				.drv    (wide_drv[j])
			);
			assign wide_pin_out[j] = wide_drv[j].out;
			assign wide_pin_oe[j]  = wide_drv[j].oe;
			assign wide_rd[j]      = wide_drv[j].rd;
		end
	endgenerate

	// First UART receive on bit 5, or bit 4 when swapped; serial data in on bit 5
	assign first_uart_receive  = wide_swap ? (wide_dir_q[0] ? 1'b1 : wide_pin_in[0])
	                                       : (wide_dir_q[1] ? 1'b1 : wide_pin_in[1]);
	assign sync_serial_data_in = wide_dir_q[1] ? 1'b1 : wide_pin_in[1];

	////////////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// Write commit with byte lane 0, and a read address taken
	sequence s_write_commit; wr_fire && wstrb0_q; endsequence
	sequence s_read_taken; s_axi_arvalid && s_axi_arready; endsequence
	// Reset is the trigger here, so the default disable would hide every attempt
	AST_RESET_CLEARS: assert property (@(posedge clock) disable iff (1'b0) rst |=> (nar_dir_q == 2'h0
		&& nar_pu_q == 2'h0 && nar_drive_q == 2'h0 && nar_func_q == 2'h0 && nar_latch_q == 2'h0
		&& wide_dir_q == 4'h0 && wide_func_q == 3'h0 && wide_drive_q == 4'h0 && wide_latch_q == 4'h0))
		else $error("control bits not clear after reset");
	AST_DIR_WRITE_LANDS: assert property (s_write_commit and (wr_sel == DGP_REG_NAR_DIR)
		|=> nar_dir_q == $past(wdata_q[1:0])) else $error("narrow direction write lost");
	AST_WIDE_DRIVE_FIELD: assert property (s_write_commit and (wr_sel == DGP_REG_WIDE_DRIVE)
		|=> wide_drive_q == $past(wdata_q[7:4])) else $error("wide drive type not from bits 7 to 4");
	AST_WIDE_LOW_ZERO: assert property (s_read_taken and (rd_sel == DGP_REG_WIDE_LATCH)
		|=> s_axi_rdata[3:0] == 4'h0 && s_axi_rdata[7:4] == $past(wide_latch_q))
		else $error("wide latch low nibble not zero");
	AST_UNUSED_ZERO: assert property (s_read_taken and (rd_sel == DGP_REG_NAR_FUNC)
		|=> s_axi_rdata[31:2] == 30'h0000_0000) else $error("unused narrow bits read nonzero");
	AST_RX_SWAP: assert property (nar_swap && !nar_dir_q[0] |-> second_uart_receive == narrow_pin_in[0])
		else $error("second UART receive not on swapped pin");
	AST_SCLK_ROUTE: assert property (wide_dir_q[2] && wide_func_q[2] && !wide_drive_q[2]
		|-> wide_pin_oe[2] && wide_pin_out[2] == sync_serial_clock) else $error("serial clock not driven on bit 6");
	AST_TOP_PIN_PORT_ONLY: assert property (wide_dir_q[3] && !wide_drive_q[3]
		|-> wide_pin_out[3] == wide_latch_q[3]) else $error("top wide pin left port function");
	generate
		for (genvar k = 0; k < NAR_W; k++)
		begin : g_nar_chk
			AST_OD_NO_HIGH: assert property (nar_drive_q[k] |-> !(narrow_pin_oe[k] && narrow_pin_out[k]))
				else $error("open drain pin driven high");
			AST_PULLUP_GATE: assert property (narrow_pullup_on[k]
				== (nar_pu_q[k] && (!nar_dir_q[k] || nar_drive_q[k]))) else $error("pull-up gate wrong");
			AST_LATCH_LOW: assert property (nar_dir_q[k] && !nar_func_q[k] && !nar_latch_q[k]
				|-> narrow_pin_oe[k] && !narrow_pin_out[k]) else $error("narrow latch zero not driving low");
			AST_FUNC_TX: assert property (nar_dir_q[k] && nar_func_q[k] && !nar_drive_q[k]
				|-> narrow_pin_out[k] == second_uart_transmit) else $error("narrow pin not carrying UART transmit");
			AST_NAR_READ: assert property (nar_dir_q[k] && !nar_drive_q[k] |-> !nar_rd[k])
				else $error("push-pull narrow read not zero");
		end
		for (genvar m = 0; m < WIDE_W; m++)
		begin : g_wide_chk
			AST_WIDE_INPUT: assert property (!wide_dir_q[m] |-> !wide_pin_oe[m])
				else $error("wide input pin driven");
			AST_WIDE_LATCH: assert property (wide_dir_q[m] && !wide_fen[m] && !wide_drive_q[m]
				|-> wide_pin_oe[m] && wide_pin_out[m] == wide_latch_q[m]) else $error("wide latch not on pin");
			AST_WIDE_READ: assert property ((!wide_dir_q[m] || wide_drive_q[m])
				|-> wide_rd[m] == wide_pin_in[m]) else $error("wide read not live pin");
		end
	endgenerate

endmodule // dgp_top

//--- bench/dgp_board_model.sv
// Purpose: Board around the port pins; resolves the level of every wire.
// Assumes: Bench supplies an external level and enable per pin.
// Notes:   A wire nobody holds flips every cycle, so no stale level is read.
module dgp_board_model
(
	input  wire logic       clock,
	input  wire logic [1:0] nar_out,
	input  wire logic [1:0] nar_oe,
	input  wire logic [1:0] nar_pu,
	input  wire logic [1:0] nar_ext,
	input  wire logic [1:0] nar_ext_en,
	output logic      [1:0] nar_wire,
	input  wire logic [3:0] wide_out,
	input  wire logic [3:0] wide_oe,
	input  wire logic [3:0] wide_ext,
	input  wire logic [3:0] wide_ext_en,
	output logic      [3:0] wide_wire
);
	timeunit 1ns;
	timeprecision 1ns;
	logic float_q = 1'b0;

	////////////////////////////////////////////////////////////////////////////
	// Floating level changes each cycle; the simulator must not pick one
	always @(posedge clock)
		float_q <= !float_q;

	// Device drive wins, then the board, then the pull-up, else float
	assign nar_wire = (nar_oe & nar_out) | (~nar_oe & nar_ext_en & nar_ext)
		| (~nar_oe & ~nar_ext_en & (nar_pu | {2{float_q}}));
	// No pull-up exists on the wide port
	assign wide_wire = (wide_oe & wide_out) | (~wide_oe & wide_ext_en & wide_ext)
		| (~wide_oe & ~wide_ext_en & {4{float_q}});
endmodule // dgp_board_model

//--- bench/test_dual_gpio_port_uart_serial_mux.sv
// Purpose: Register and pin checks of the dual port block over AXI4-Lite.
// Assumes: Byte address is four times the register index.
// Notes:   Pins are checked one edge after the inputs settle.
`include "dgp_params.svh"
module test_dual_gpio_port_uart_serial_mux
	import dgp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clock = 1'b0, rst = 1'b1;
	logic [15:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'h0, wide_pin_in, wide_pin_out, wide_pin_oe, wide_ext = 4'hf, wide_ext_en = 4'hf;
	logic [1:0]  s_axi_bresp, s_axi_rresp, narrow_pin_in, narrow_pin_out, narrow_pin_oe, narrow_pullup_on;
	logic [1:0]  nar_ext = 2'h2, nar_ext_en = 2'h3;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        second_uart_transmit = 1'b0, first_uart_transmit = 1'b0, sync_serial_clock = 1'b0;
	logic        sync_serial_data_out = 1'b0, second_uart_receive, first_uart_receive, sync_serial_data_in;
	int          n_errors = 0, check_count = 0;
	logic [3:0]  wr_strb = 4'hf;
	logic [11:0] idx_tab [9] = '{`DGP_IDX_NAR_LATCH, `DGP_IDX_WIDE_LATCH, `DGP_IDX_NAR_DIR, `DGP_IDX_WIDE_DIR,
		`DGP_IDX_NAR_PU, `DGP_IDX_NAR_FUNC, `DGP_IDX_WIDE_FUNC, `DGP_IDX_NAR_DRIVE, `DGP_IDX_WIDE_DRIVE};
	logic [7:0]  mask_tab [9] = '{8'h03, 8'hf0, 8'h03, 8'hf0, 8'h03, 8'h03, 8'h70, 8'h03, 8'hf0};

	dgp_top u_dgp_top (.clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .narrow_pin_in, .narrow_pin_out,
		.narrow_pin_oe, .narrow_pullup_on, .wide_pin_in, .wide_pin_out, .wide_pin_oe, .second_uart_transmit,
		.second_uart_receive, .first_uart_transmit, .first_uart_receive, .sync_serial_clock,
		.sync_serial_data_out, .sync_serial_data_in);
	dgp_board_model u_dgp_board_model (.clock, .nar_out(narrow_pin_out), .nar_oe(narrow_pin_oe),
		.nar_pu(narrow_pullup_on), .nar_ext, .nar_ext_en, .nar_wire(narrow_pin_in), .wide_out(wide_pin_out),
		.wide_oe(wide_pin_oe), .wide_ext, .wide_ext_en, .wide_wire(wide_pin_in));

	////////////////////////////////////////////////////////////////////////////
	// Compare and count
	task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
		check_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Write one word; address and data offered together, each released when taken
	task automatic wr(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] er);
		@(posedge clock);
		s_axi_awaddr <= {2'b00, idx, 2'b00};
		s_axi_wdata <= {24'h00_0000, d};
		s_axi_wstrb <= wr_strb;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge clock);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk($sformatf("write %h", idx), {29'h0, 1'b1, er}, {29'h0, s_axi_bvalid, s_axi_bresp});
	endtask

	// Read one word; the bench timeout is the only limit on the wait
	task automatic rd(input logic [11:0] idx, input logic [7:0] exp, input logic [1:0] er);
		@(posedge clock);
		s_axi_araddr <= {2'b00, idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge clock);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk($sformatf("read %h", idx), {5'h0, 1'b1, er, 24'h0, exp}, {5'h0, s_axi_rvalid, s_axi_rresp, s_axi_rdata});
	endtask

	////////////////////////////////////////////////////////////////////////////
	always #20 clock = ~clock;

	// Cut a hang well past the expected few hundred cycles
	initial
	begin
		#(40 * 5000);
		n_errors++;
		tally_and_finish();
	end

	initial
	begin
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		chk("pins after reset", 32'h0, {24'h0, narrow_pullup_on, narrow_pin_oe, wide_pin_oe});
		for (int i = 0; i < 9; i++)
		begin
			rd(idx_tab[i], 8'h00, DGP_RESP_OKAY);
			wr(idx_tab[i], 8'hff, DGP_RESP_OKAY);
			rd(idx_tab[i], mask_tab[i], DGP_RESP_OKAY);
			wr(idx_tab[i], 8'h00, DGP_RESP_OKAY);
		end
		wr(12'h123, 8'h55, DGP_RESP_SLVERR);
		rd(12'h123, 8'h00, DGP_RESP_SLVERR);
		rd(`DGP_IDX_NAR_PIN, 8'h02, DGP_RESP_OKAY);
		rd(`DGP_IDX_WIDE_PIN, 8'hf0, DGP_RESP_OKAY);
		chk("receive on pin1", 32'h1, {31'h0, second_uart_receive});
		nar_ext <= 2'h1;
		@(posedge clock);
		chk("receive low", 32'h0, {31'h0, second_uart_receive});
		wr(`DGP_IDX_ROUTE, 8'h01, DGP_RESP_OKAY);
		chk("swapped receive", 32'h1, {31'h0, second_uart_receive});
		// Push-pull output, then pull-up request that must stay off
		wr(`DGP_IDX_NAR_LATCH, 8'h01, DGP_RESP_OKAY);
		wr(`DGP_IDX_NAR_DIR, 8'h03, DGP_RESP_OKAY);
		wr(`DGP_IDX_NAR_PU, 8'h03, DGP_RESP_OKAY);
		chk("narrow push-pull", 32'h0d, {24'h0, narrow_pullup_on, narrow_pin_oe, narrow_pin_out});
		rd(`DGP_IDX_NAR_PIN, 8'h00, DGP_RESP_OKAY);
		nar_ext_en <= 2'h0;
		wr(`DGP_IDX_NAR_DRIVE, 8'h03, DGP_RESP_OKAY);
		chk("narrow open drain", 32'h38, {24'h0, narrow_pullup_on, narrow_pin_oe, narrow_pin_out});
		rd(`DGP_IDX_NAR_PIN, 8'h01, DGP_RESP_OKAY);
		wr(`DGP_IDX_NAR_DRIVE, 8'h00, DGP_RESP_OKAY);
		wr(`DGP_IDX_NAR_FUNC, 8'h02, DGP_RESP_OKAY);
		second_uart_transmit <= 1'b1;
		@(posedge clock);
		chk("transmit high", 32'h3, {30'h0, narrow_pin_out});
		second_uart_transmit <= 1'b0;
		@(posedge clock);
		chk("transmit low", 32'h1, {30'h0, narrow_pin_out});
		// Wide port: push-pull, open drain, then routed functions
		wr(`DGP_IDX_WIDE_LATCH, 8'ha0, DGP_RESP_OKAY);
		wr(`DGP_IDX_WIDE_DIR, 8'hf0, DGP_RESP_OKAY);
		chk("wide push-pull", 32'hfa, {24'h0, wide_pin_oe, wide_pin_out});
		rd(`DGP_IDX_WIDE_PIN, 8'h00, DGP_RESP_OKAY);
		wr(`DGP_IDX_WIDE_DRIVE, 8'hf0, DGP_RESP_OKAY);
		chk("wide open drain", 32'h50, {24'h0, wide_pin_oe, wide_pin_out});
		rd(`DGP_IDX_WIDE_PIN, 8'ha0, DGP_RESP_OKAY);
		wr(`DGP_IDX_WIDE_DRIVE, 8'h00, DGP_RESP_OKAY);
		wr(`DGP_IDX_WIDE_LATCH, 8'h00, DGP_RESP_OKAY);
		sync_serial_clock <= 1'b1;
		first_uart_transmit <= 1'b1;
		wr(`DGP_IDX_WIDE_FUNC, 8'h70, DGP_RESP_OKAY);
		chk("wide functions", 32'h7, {28'h0, wide_pin_out});
		wr(`DGP_IDX_ROUTE, 8'h04, DGP_RESP_OKAY);
		chk("serial data out", 32'h6, {28'h0, wide_pin_out});
		first_uart_transmit <= 1'b0;
		@(posedge clock);
		chk("uart transmit low", 32'h4, {28'h0, wide_pin_out});
		wide_ext <= 4'h2;
		wr(`DGP_IDX_WIDE_DIR, 8'h00, DGP_RESP_OKAY);
		chk("wide inputs", 32'h3, {30'h0, sync_serial_data_in, first_uart_receive});
		wr(`DGP_IDX_ROUTE, 8'h02, DGP_RESP_OKAY);
		chk("wide receive swapped", 32'h0, {31'h0, first_uart_receive});
		// Mid-run reset clears everything set above; board drives the narrow pins again
		nar_ext_en <= 2'h3;
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		chk("pins after second reset", 32'h0, {24'h0, narrow_pullup_on, narrow_pin_oe, wide_pin_oe});
		rd(`DGP_IDX_NAR_DIR, 8'h00, DGP_RESP_OKAY);
		rd(`DGP_IDX_WIDE_FUNC, 8'h00, DGP_RESP_OKAY);
		rd(`DGP_IDX_ROUTE, 8'h00, DGP_RESP_OKAY);
		// Pin-read register ignores writes; lane 0 off stores nothing
		wr(`DGP_IDX_NAR_PIN, 8'hff, DGP_RESP_OKAY);
		rd(`DGP_IDX_NAR_PIN, 8'h01, DGP_RESP_OKAY);
		wr_strb = 4'he;
		wr(`DGP_IDX_NAR_LATCH, 8'h03, DGP_RESP_OKAY);
		wr_strb = 4'hf;
		rd(`DGP_IDX_NAR_LATCH, 8'h00, DGP_RESP_OKAY);
		tally_and_finish();
	end
endmodule // test_dual_gpio_port_uart_serial_mux
